// File: dv/isow_host_model.sv
// Host model: drives every logic input of the block except clock and reset to a defined level.
`timescale 1ns/1ps
`default_nettype none
module isow_host_model
(
  input  wire logic        i_clock,
  input  wire logic [14:0] i_cmd,
  output var  logic [14:0] o_pins
);
  // Pins move on the falling edge only, so the block never samples a changing input.
  initial o_pins = 15'h0000;
  always @(negedge i_clock) o_pins <= i_cmd;
endmodule : isow_host_model
`default_nettype wire

// File: dv/isow_properties.sv
// Port assertions for the switch output logic, bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module isow_properties
  import isow_pkg::*;
#(parameter int unsigned N_CH = CHANNELS)
(
  input wire logic            i_clock,
  input wire logic            i_rst,
  input wire logic [N_CH-1:0] i_channel_input,
  input wire logic            i_output_gate,
  input wire logic            i_logic_supply_ok,
  input wire isow_sup_cmp_t   i_switch_supply,
  input wire isow_fault_src_t i_fault_src,
  input wire logic [N_CH-1:0] o_channel_switch_output,
  input wire logic [N_CH-1:0] o_channel_status_led_n_oe,
  input wire logic            o_fault_indicator_n_oe,
  input wire logic            o_switch_supply_low_n_oe,
  input wire logic            o_open_load_indicator_n_oe,
  input wire isow_supply_t    o_supply_state
);
  wire logic [N_CH-1:0] sw   = o_channel_switch_output;
  wire logic [N_CH-1:0] want = i_channel_input & {N_CH{i_output_gate}};
  wire logic            run_ok = i_logic_supply_ok && i_switch_supply.above_lower
                                 && !i_fault_src.other && o_supply_state != ISOW_SUP_NOT_POWERED;
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_normal_drive: assert property (run_ok && !i_fault_src.over_temp |=>
    sw == $past(want)) else $error("Switch ignores its command.");
  a_fault_blocks: assert property (i_logic_supply_ok && i_fault_src.other |=>
    o_fault_indicator_n_oe && sw == '0) else $error("Fault not handled.");
  a_supply_off: assert property (!i_switch_supply.above_lower |=>
    sw == '0) else $error("Switch on without supply.");
  a_volt_flags: assert property (run_ok && i_fault_src.over_volt |=>
    o_fault_indicator_n_oe) else $error("Overvoltage not flagged.");
  a_temp_no_start: assert property (i_fault_src.over_temp |=>
    (sw & ~$past(sw)) == '0) else $error("Turned on while hot.");
  a_temp_holds: assert property (run_ok && i_fault_src.over_temp |=>
    sw == ($past(sw) & $past(want))) else $error("Hot output not held.");
  a_led_mirror: assert property (o_channel_status_led_n_oe == sw)
    else $error("LED differs from switch.");
  a_logic_off: assert property (!i_logic_supply_ok |=> sw == '0
    && !o_switch_supply_low_n_oe && !o_open_load_indicator_n_oe) else $error("Not off.");
endmodule : isow_properties
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the switch output logic, both indicator variants.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import isow_pkg::*;
  typedef struct packed {logic [14:0] pins; logic [11:0] wt; logic [6:0] exp;} isow_row_t;
  isow_row_t rows [18] = '{
    '{15'h7c18, 12'h44c, 7'h00}, '{15'h7ff8, 12'h003, 7'h78},
    '{15'h7d58, 12'h003, 7'h00}, '{15'h7d78, 12'h003, 7'h28},
    '{15'h7ff9, 12'h003, 7'h04}, '{15'h7ffa, 12'h003, 7'h7c},
    '{15'h7ffc, 12'h003, 7'h7c}, '{15'h7c3c, 12'h003, 7'h04},
    '{15'h7ffc, 12'h003, 7'h04}, '{15'h7cf0, 12'h44c, 7'h1a},
    '{15'h7ce0, 12'h44c, 7'h06}, '{15'h7cf8, 12'h44c, 7'h18},
    '{15'h7cf0, 12'h032, 7'h18}, '{15'h7cf8, 12'h44c, 7'h18},
    '{15'h3ff8, 12'h003, 7'h00}, '{15'h7838, 12'h032, 7'h00},
    '{15'h7838, 12'h44c, 7'h01}, '{15'h7878, 12'h44c, 7'h08}
  };
  logic        i_clock = 1'h0, i_rst = 1'h1;
  logic [14:0] cmd = 15'h0000, pins;
  logic [6:0]  e;
  logic [3:0]  sw [2], led [2];
  logic [1:0]  flt, wrn, opn;
  isow_supply_t st [2];
  int          mismatches = 0, checks_done = 0, cycles = 0;
  always #5 i_clock = ~i_clock;
  isow_host_model host_u (.i_clock(i_clock), .i_cmd(cmd), .o_pins(pins));
  for (genvar g = 0; g < 2; g++)
  begin : v
    isow_output_logic #(.N_CH(4), .VARIANT(isow_variant_t'(g))) dut_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_logic_supply_ok(pins[14]), .i_fault_src(pins[2:0]),
      .i_load_present(pins[13:10]), .i_channel_input(pins[9:6]), .i_output_gate(pins[5]),
      .i_switch_supply(pins[4:3]), .o_channel_switch_output(sw[g]), .o_supply_state(st[g]),
      .o_channel_status_led_n_oe(led[g]), .o_fault_indicator_n_oe(flt[g]),
      .o_switch_supply_low_n_oe(wrn[g]), .o_open_load_indicator_n_oe(opn[g]));
  end
  task automatic check(input logic ok, input string what);
    checks_done++;
    mismatches += int'(ok !== 1'h1);
    if (ok !== 1'h1)
      $display("Error at %0t: %s", $time, what);
  endtask : check
  task automatic give_verdict(input int extra);
    mismatches += extra;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  always @(posedge i_clock)
    if (++cycles == 10000)
      give_verdict(1);
  initial
  begin
    repeat (20) @(posedge i_clock);
    #1 check({sw[0], sw[1], flt, wrn, opn} === 14'h0000, "outputs in reset");
    @(negedge i_clock) i_rst = 1'h0;
    @(posedge i_clock);
    foreach (rows[i])
    begin
      e = rows[i].exp;
      cmd = rows[i].pins;
      repeat (rows[i].wt) @(posedge i_clock);
      #1 check({sw[0], sw[1], led[0], flt[0], wrn[0], opn} === {{3{e[6:3]}}, e[2:0], 1'h0},
               $sformatf("row %0d", i));
    end
    check(st[0] === ISOW_SUP_POWERED && st[1] === ISOW_SUP_POWERED, "supply class");
    give_verdict(0);
  end
endmodule : tb
bind isow_output_logic isow_properties #(.N_CH(N_CH)) chk_u (.*);
`default_nettype wire

// File: rtl/isow_output_logic.sv
// Output logic for a four-channel isolated smart switch, both indicator variants.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------

module isow_output_logic
  import isow_pkg::*;
#(
  parameter int unsigned   N_CH    = CHANNELS,
  parameter isow_variant_t VARIANT = ISOW_VARIANT_WARNING
)
(
  input  wire logic            i_clock,
  input  wire logic            i_rst,
  input  wire logic [N_CH-1:0] i_channel_input,
  input  wire logic            i_output_gate,
  input  wire logic            i_logic_supply_ok,
  input  wire isow_sup_cmp_t   i_switch_supply,
  input  wire isow_fault_src_t i_fault_src,
  input  wire logic [N_CH-1:0] i_load_present,
  output logic [N_CH-1:0]      o_channel_switch_output,
  output logic [N_CH-1:0]      o_channel_status_led_n_oe,
  output logic                 o_fault_indicator_n_oe,
  output logic                 o_switch_supply_low_n_oe,
  output logic                 o_open_load_indicator_n_oe,
  output isow_supply_t         o_supply_state
);

  // ---------------------------------------------------------------------------
  // Supply classification and settle filters
  // ---------------------------------------------------------------------------
  isow_supply_t        sup_now;
  isow_supply_t        sup_stable_q, sup_stable_d;
  isow_supply_t        sup_prev_q, sup_prev_d;
  isow_supply_t        sup_cand_q, sup_cand_d;
  logic [SETTLE_W-1:0] sup_cnt_q, sup_cnt_d;
  logic                load_ok_now;
  logic                load_stable_q, load_stable_d;
  logic                load_prev_q, load_prev_d;
  logic                load_cand_q, load_cand_d;
  logic [SETTLE_W-1:0] load_cnt_q, load_cnt_d;

  // True on the last cycle of a settle count; shared by both filters.
  function automatic logic settled(input logic [SETTLE_W-1:0] cnt);
    return cnt == SETTLE_LAST;
  endfunction : settled

  always_comb
  begin
    if (!i_switch_supply.above_lower)
      sup_now = ISOW_SUP_NOT_POWERED;
    else if (!i_switch_supply.above_upper)
      sup_now = ISOW_SUP_WARNING;
    else
      sup_now = ISOW_SUP_POWERED;
  end

  always_comb
  begin
    sup_cand_d   = sup_now;
    sup_cnt_d    = '0;
    sup_stable_d = sup_stable_q;
    sup_prev_d   = sup_prev_q;
    // A new state must hold SETTLE_CYCLES before it is taken as measured.
    // Any change of class restarts the count, so a supply that wanders
    // between classes faster than that leaves the indicator untouched.
    if (sup_now == sup_cand_q && sup_now != sup_stable_q)
    begin
      sup_cnt_d = sup_cnt_q + SETTLE_W'(1);
      if (settled(sup_cnt_q))
      begin
        sup_stable_d = sup_now;
        sup_prev_d   = sup_stable_q;
        sup_cnt_d    = '0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sup_stable_q <= ISOW_SUP_NOT_POWERED;
      sup_prev_q   <= ISOW_SUP_NOT_POWERED;
      sup_cand_q   <= ISOW_SUP_NOT_POWERED;
      sup_cnt_q    <= '0;
    end
    else
    begin
      sup_stable_q <= sup_stable_d;
      sup_prev_q   <= sup_prev_d;
      sup_cand_q   <= sup_cand_d;
      sup_cnt_q    <= sup_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Load settle filter
  // ---------------------------------------------------------------------------
  // A driven channel counts as loaded, since an open load can only be seen
  // while its switch is off.
  always_comb
  begin
    load_ok_now   = &(i_load_present | o_channel_switch_output);
    load_cand_d   = load_ok_now;
    load_cnt_d    = '0;
    load_stable_d = load_stable_q;
    load_prev_d   = load_prev_q;
    if (load_ok_now == load_cand_q && load_ok_now != load_stable_q)
    begin
      load_cnt_d = load_cnt_q + SETTLE_W'(1);
      if (settled(load_cnt_q))
      begin
        load_stable_d = load_ok_now;
        load_prev_d   = load_stable_q;
        load_cnt_d    = '0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      load_stable_q <= 1'b1;
      load_prev_q   <= 1'b1;
      load_cand_q   <= 1'b1;
      load_cnt_q    <= '0;
    end
    else
    begin
      load_stable_q <= load_stable_d;
      load_prev_q   <= load_prev_d;
      load_cand_q   <= load_cand_d;
      load_cnt_q    <= load_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Fault state and channel outputs
  // ---------------------------------------------------------------------------
  // The switch path uses the raw supply level, not the filtered one, so that a
  // collapsing supply shuts outputs off at once.
  logic            fault_now;
  logic            hard_fault;
  logic [N_CH-1:0] sw_d;
  logic [N_CH-1:0] led_oe_d;
  logic            flt_oe_d;
  logic            wrn_oe_d;
  logic            open_oe_d;

  always_comb
  begin
    // Faults are not latched: the fault state drops by itself as soon as
    // every source has gone, which is what the host expects.
    hard_fault = (sup_now == ISOW_SUP_NOT_POWERED) | i_fault_src.other;
    fault_now  = hard_fault | i_fault_src.over_temp | i_fault_src.over_volt;
    for (int i = 0; i < int'(N_CH); i++)
    begin
      // Over-temperature only blocks turn-on; overvoltage does not gate at all.
      sw_d[i] = i_channel_input[i] & i_output_gate & ~hard_fault
                & (o_channel_switch_output[i] | ~i_fault_src.over_temp);
      if (!i_logic_supply_ok)
        sw_d[i] = 1'b0;
    end
    led_oe_d = sw_d;
    // With no logic supply the fault pin is undetermined; it is released here.
    flt_oe_d = i_logic_supply_ok & fault_now;
    wrn_oe_d = 1'b0;
    open_oe_d = 1'b0;
    if (i_logic_supply_ok && VARIANT == ISOW_VARIANT_WARNING)
      wrn_oe_d = (sup_stable_q == ISOW_SUP_WARNING)
                 | (sup_stable_q == ISOW_SUP_NOT_POWERED && sup_prev_q == ISOW_SUP_WARNING);
    // A supply that has just collapsed still reports a load that went
    // missing before the collapse, so that the host does not lose it.
    if (i_logic_supply_ok && VARIANT == ISOW_VARIANT_OPEN_LOAD)
      open_oe_d = ~load_stable_q
                  | (sup_stable_q == ISOW_SUP_NOT_POWERED
                     && sup_prev_q != ISOW_SUP_NOT_POWERED && ~load_prev_q);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_channel_switch_output    <= {N_CH{RESET_OUT}};
      o_channel_status_led_n_oe  <= {N_CH{RESET_OUT}};
      o_fault_indicator_n_oe     <= RESET_OUT;
      o_switch_supply_low_n_oe   <= RESET_OUT;
      o_open_load_indicator_n_oe <= RESET_OUT;
      o_supply_state             <= ISOW_SUP_NOT_POWERED;
    end
    else
    begin
      o_channel_switch_output    <= sw_d;
      o_channel_status_led_n_oe  <= led_oe_d;
      o_fault_indicator_n_oe     <= flt_oe_d;
      o_switch_supply_low_n_oe   <= wrn_oe_d;
      o_open_load_indicator_n_oe <= open_oe_d;
      o_supply_state             <= sup_stable_q;
    end
  end

endmodule : isow_output_logic

`default_nettype wire

// File: shared/isow_pkg.sv
// Package for the isolated switch output logic: constants, types and carriers.
`default_nettype none

package isow_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and counts
  // ---------------------------------------------------------------------------
  localparam int unsigned CHANNELS         = 4;
  localparam int unsigned CLOCK_MHZ        = 100;
  // Time a supply or load state must hold before the warning and open-load indicators follow it.
  localparam int unsigned SETTLE_TIME_US   = 10;
  localparam int unsigned SETTLE_CYCLES    = SETTLE_TIME_US * CLOCK_MHZ;
  localparam int unsigned SETTLE_W         = 11;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // Variant selection
  // ---------------------------------------------------------------------------
  typedef enum logic
  {
    ISOW_VARIANT_WARNING,
    ISOW_VARIANT_OPEN_LOAD
  } isow_variant_t;

  // ---------------------------------------------------------------------------
  // Supply classification
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ISOW_SUP_NOT_POWERED,
    ISOW_SUP_WARNING,
    ISOW_SUP_POWERED
  } isow_supply_t;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed
  {
    logic above_lower;
    logic above_upper;
  } isow_sup_cmp_t;

  typedef struct packed
  {
    logic over_temp;
    logic over_volt;
    logic other;
  } isow_fault_src_t;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic RESET_IND_N = 1'b1;
  localparam logic RESET_OUT   = 1'b0;

endpackage : isow_pkg

`default_nettype wire
